// *** design/data_nvm_register_access.sv ***
// Register access block for the byte-wide data NVM: data, address, control and unlock port on APB.
// Assumes a 32-bit APB master on the same clock, reset as power-on reset, soft_reset as any other reset.
`include "nvm_cfg.svh"
`default_nettype none

// What this block does
// - Access works regardless of code protection.
// - Data and address survive non-power-on resets.
// - Control register upper four bits read zero.
// - Resets clear permit and go bits; abort flag.
// - Unlock port stores nothing, reads zero.
// - Read go loads data next cycle, self-clears.
// - Write go needs permit; hardware clears permit only on reset.
// - Write end clears write go, sets done flag.
module data_nvm_register_access
  import nvm_pkg::*;
#(
  parameter int unsigned AW           = 7,
  parameter int unsigned PADDR_W      = 12,
  parameter int unsigned WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
  // Clock, resets and enable.
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               soft_reset,
  input  wire logic               ce,
  // Device protection state, shown but never used as a gate.
  input  wire logic               code_protect,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr
);

  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;
  logic [7:0]    data_r;
  logic [7:0]    addr_r;
  ctrl_bits_t    ctrl_r;
  logic          done_flag_r;
  logic          prot_r;
  unlock_state_t unlock_r;
  unlock_state_t unlock_nxt;

  logic [9:0]    idx;
  logic          complete;
  logic          wr_acc;
  logic          wr_data;
  logic          wr_addr;
  logic          wr_ctrl;
  logic          wr_unlock;
  logic          wr_flag;
  logic          start_write;
  logic [31:0]   rd_val;
  logic          hit;
  logic [7:0]    arr_rd;
  logic          arr_busy;
  logic          arr_done;

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // A transfer completes at the edge where the access phase meets pready.
  assign idx       = paddr[PADDR_W-1:2];
  assign complete  = psel && penable && pready_r;
  assign wr_acc    = complete && pwrite;
  assign wr_data   = wr_acc && idx == `NVM_DATA_IDX;
  assign wr_addr   = wr_acc && idx == `NVM_ADDR_IDX;
  assign wr_ctrl   = wr_acc && idx == `NVM_CTRL_IDX;
  assign wr_unlock = wr_acc && idx == `NVM_UNLOCK_IDX;
  assign wr_flag   = wr_acc && idx == `NVM_FLAG_IDX;

  // The go bit is only taken right after both keys and while writes are permitted.
  assign start_write = wr_ctrl && pwdata[`NVM_WGO_BIT] && ctrl_r.permit
                       && unlock_r == UNLOCK_GOT_2 && !ctrl_r.wgo;

  // Read data selection; the unlock port and reserved bits read as zero.
  always_comb
  begin
    rd_val = `NVM_ZERO_WORD;
    hit    = 1'b1;
    unique case (idx)
      `NVM_DATA_IDX:   rd_val[7:0] = data_r;
      `NVM_ADDR_IDX:   rd_val[7:0] = addr_r;
      `NVM_CTRL_IDX:   rd_val[3:0] = ctrl_r;
      `NVM_UNLOCK_IDX: rd_val      = `NVM_ZERO_WORD;
      `NVM_FLAG_IDX:
      begin
        rd_val[`NVM_DONE_BIT] = done_flag_r;
        rd_val[`NVM_BUSY_BIT] = arr_busy;
        rd_val[`NVM_PROT_BIT] = prot_r;
      end
      default:         hit = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle with registered data.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= `NVM_ZERO_WORD;
    end
    else if (ce)
    begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !hit;
      if (psel && penable && !pready_r)
        prdata_r <= (pwrite || !hit) ? `NVM_ZERO_WORD : rd_val;
    end
  end

  // Unlock sequence: any transfer other than the expected next step starts over.
  always_comb
  begin
    unlock_nxt = unlock_r;
    if (complete)
    begin
      unlock_nxt = UNLOCK_IDLE;
      if (wr_unlock && pwdata[7:0] == `NVM_KEY_FIRST && unlock_r == UNLOCK_IDLE)
        unlock_nxt = UNLOCK_GOT_1;
      else if (wr_unlock && pwdata[7:0] == `NVM_KEY_SECOND && unlock_r == UNLOCK_GOT_1)
        unlock_nxt = UNLOCK_GOT_2;
    end
  end

  // The keys written to the port feed only this detector and are not stored.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      unlock_r <= UNLOCK_IDLE;
    else if (ce)
    begin
      if (soft_reset)
        unlock_r <= UNLOCK_IDLE;
      else
        unlock_r <= unlock_nxt;
    end
  end

  // Control bits; soft reset records whether a write was cut short.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      ctrl_r <= `NVM_CTRL_RESET;
    else if (ce)
    begin
      if (soft_reset)
      begin
        ctrl_r.abort  <= arr_busy;
        ctrl_r.permit <= 1'b0;
        ctrl_r.wgo    <= 1'b0;
        ctrl_r.rgo    <= 1'b0;
      end
      else
      begin
        // Read go lives exactly one cycle; writing zero has no effect.
        ctrl_r.rgo <= wr_ctrl && pwdata[`NVM_RGO_BIT];
        if (arr_done)
          ctrl_r.wgo <= 1'b0;
        else if (start_write)
          ctrl_r.wgo <= 1'b1;
        if (wr_ctrl)
        begin
          ctrl_r.permit <= pwdata[`NVM_PERMIT_BIT];
          ctrl_r.abort  <= pwdata[`NVM_ABORT_BIT];
        end
      end
    end
  end

  // Done flag: set by completion, cleared by writing one; a same-cycle set wins.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      done_flag_r <= 1'b0;
    else if (ce)
    begin
      if (arr_done)
        done_flag_r <= 1'b1;
      else if (wr_flag && pwdata[`NVM_DONE_BIT])
        done_flag_r <= 1'b0;
    end
  end

  // Protection is reported only; nothing in the access path looks at it.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      prot_r <= 1'b0;
    else if (ce)
      prot_r <= code_protect;
  end

  // Data and address carry no reset, so every reset leaves them as they were.
  always_ff @(posedge clock)
  begin
    if (ce)
    begin
      if (ctrl_r.rgo)
        data_r <= arr_rd;
      else if (wr_data)
        data_r <= pwdata[7:0];
      if (wr_addr)
        addr_r <= pwdata[7:0];
    end
  end

  // Array with its timed write; a soft reset mid-write aborts the cell update.
  nvm_array #(
    .AW           (AW),
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_array (
    .clock    (clock),
    .reset    (reset),
    .ce       (ce),
    .rd_addr  (addr_r[AW-1:0]),
    .rd_data  (arr_rd),
    .wr_start (start_write && !soft_reset),
    .wr_addr  (addr_r[AW-1:0]),
    .wr_data  (data_r),
    .abort    (soft_reset),
    .busy     (arr_busy),
    .done     (arr_done)
  );

endmodule : data_nvm_register_access

`default_nettype wire

// *** design/nvm_cfg.svh ***
// Constants for the data NVM register block: word indexes, field positions, reset values, timing.
// Assumes a 32-bit APB with one register per aligned word; byte address is four times the index.
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH

// Word indexes of the registers.
`define NVM_DATA_IDX      10'h09A
`define NVM_ADDR_IDX      10'h09B
`define NVM_CTRL_IDX      10'h09C
`define NVM_UNLOCK_IDX    10'h09D
`define NVM_FLAG_IDX      10'h00C

// Field positions in the control register.
`define NVM_RGO_BIT       0
`define NVM_WGO_BIT       1
`define NVM_PERMIT_BIT    2
`define NVM_ABORT_BIT     3

// Field positions in the flag register.
`define NVM_DONE_BIT      0
`define NVM_BUSY_BIT      1
`define NVM_PROT_BIT      2

// Unlock keys and reset values.
`define NVM_KEY_FIRST     8'h55
`define NVM_KEY_SECOND    8'hAA
`define NVM_CTRL_RESET    4'h0
`define NVM_ZERO_WORD     32'h0000_0000

// Write cycle time and the clock it is counted in.
`define NVM_WRITE_TIME_NS 4_000_000
`define NVM_CLK_PERIOD_NS 40
`define NVM_WRITE_CYCLES  (`NVM_WRITE_TIME_NS / `NVM_CLK_PERIOD_NS)

`endif

// *** design/nvm_pkg.sv ***
// Types shared by the data NVM register block.
// Assumes nvm_cfg.svh holds every numeric constant.
`default_nettype none

package nvm_pkg;

  // Control register bits, msb first as they sit in the register.
  typedef struct packed {
    logic abort;
    logic permit;
    logic wgo;
    logic rgo;
  } ctrl_bits_t;

  // Progress through the write unlock sequence.
  typedef enum logic [1:0] {
    UNLOCK_IDLE  = 2'b00,
    UNLOCK_GOT_1 = 2'b01,
    UNLOCK_GOT_2 = 2'b10
  } unlock_state_t;

endpackage : nvm_pkg

`default_nettype wire

// *** design/nvm_array.sv ***
// Byte-wide nonvolatile data array modelled in flip-flops, with a timed write cycle.
// Assumes one clock, clock enable freezing all state, and a start pulse only while idle.
`default_nettype none

module nvm_array #(
  parameter int unsigned AW           = 7,
  parameter int unsigned WRITE_CYCLES = 100
) (
  // Clock, reset and enable.
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic          ce,
  // Read port, combinational.
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data,
  // Write request and progress.
  input  wire logic          wr_start,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic          abort,
  output logic               busy,
  output logic               done
);

  localparam int unsigned CW = $clog2(WRITE_CYCLES + 1);

  logic [7:0]    mem_r [2**AW];
  logic [AW-1:0] addr_r;
  logic [7:0]    data_r;
  logic [CW-1:0] count_r;
  logic          busy_r;
  logic          done_r;

  assign rd_data = mem_r[rd_addr];
  assign busy    = busy_r;
  assign done    = done_r;

  // Latch target at start so software may change the registers mid-write.
  always_ff @(posedge clock)
  begin
    if (ce && wr_start && !busy_r)
    begin
      addr_r <= wr_addr;
      data_r <= wr_data;
    end
  end

  // Write timer; an abort drops the cell update so the byte keeps its old value.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      count_r <= '0;
    end
    else if (ce)
    begin
      done_r <= 1'b0;
      if (abort)
        busy_r <= 1'b0;
      else if (busy_r)
      begin
        if (count_r == CW'(1))
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        count_r <= count_r - CW'(1);
      end
      else if (wr_start)
      begin
        busy_r  <= 1'b1;
        count_r <= CW'(WRITE_CYCLES);
      end
    end
  end

  // Cell contents survive every reset, as nonvolatile storage should.
  always_ff @(posedge clock)
  begin
    if (ce && busy_r && !abort && count_r == CW'(1))
      mem_r[addr_r] <= data_r;
  end

endmodule : nvm_array

`default_nettype wire

// *** tb/nvm_access_sva.sv ***
// Checker for the data NVM register block: APB answer timing and fixed read-back fields.
// Assumes it is bound to the block's top module and sees only its ports.
`include "nvm_cfg.svh"
`default_nettype none

module nvm_access_sva #(
  parameter int unsigned PADDR_W = 12
) (
  // Clock, resets and state inputs.
  input wire logic               clock,
  input wire logic               reset,
  input wire logic               soft_reset,
  input wire logic               ce,
  input wire logic               code_protect,
  // APB signals.
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr
);
  // Word index and completed-read qualifier, shared by the read-back checks.
  logic [9:0] idx;
  logic       rd_done;
  logic       mapped;
  assign idx     = paddr[11:2];
  assign rd_done = pready && !pwrite;
  assign mapped  = idx inside {`NVM_DATA_IDX, `NVM_ADDR_IDX, `NVM_CTRL_IDX, `NVM_UNLOCK_IDX, `NVM_FLAG_IDX};

  default clocking dc @(posedge clock); endclocking
  default disable iff (reset);

  // Answer timing: one wait state, a single-cycle answer, only inside an access phase.
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held beyond one cycle");
  ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside an access phase");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  one_wait_a: assert property (psel && !penable && ce ##1 psel && penable && ce ##1 ce |-> pready && !$past(pready))
    else $error("answer not in second access cycle");
  // Read-back content of fixed fields.
  ctrl_upper_a: assert property (rd_done && idx == `NVM_CTRL_IDX |-> prdata[31:4] == 28'h000_0000)
    else $error("control upper bits not zero");
  unlock_zero_a: assert property (rd_done && idx == `NVM_UNLOCK_IDX |-> prdata == 32'h0000_0000)
    else $error("unlock port read not zero");
  byte_fill_a: assert property (rd_done && (idx == `NVM_DATA_IDX || idx == `NVM_ADDR_IDX) |-> prdata[31:8] == 24'h00_0000)
    else $error("byte register not zero filled");
  wr_zero_a: assert property (pready && pwrite |-> prdata == 32'h0000_0000) else $error("read data during write");
  // Protection never refuses a mapped access; unmapped ones always are.
  map_err_a: assert property (pready |-> pslverr == !mapped)
    else $error("slave error does not match map");
endmodule : nvm_access_sva

bind data_nvm_register_access nvm_access_sva #(.PADDR_W(PADDR_W)) i_sva (.clock(clock), .reset(reset),
  .soft_reset(soft_reset), .ce(ce), .code_protect(code_protect), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

`default_nettype wire

// *** tb/test_data_nvm_register_access.sv ***
// Self-checking bench for the data NVM register block, driven as an APB master.
// Assumes one wait state per access and a short write cycle set by parameter.
`include "nvm_cfg.svh"
`default_nettype none

module test_data_nvm_register_access;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, reset, soft_reset, ce, code_protect;
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  int          errors, cmp_count;

  data_nvm_register_access #(.WRITE_CYCLES(40)) i_dut (.clock(clock), .reset(reset), .soft_reset(soft_reset),
    .ce(ce), .code_protect(code_protect), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Free-running clock at 40 ns.
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // One APB transfer; an idle edge first keeps each signal to one assignment per time step.
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    @(posedge clock);
    // Wait for the answer; the limit only guards against a hung slave.
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clock);
    end
    if (pready !== 1'b1)
    begin
      errors++;
      $display("unexpected at %0t: no pready", $time);
    end
    rdv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  // Compare of read data against a zero-extended byte.
  task automatic chk(input logic [7:0] exp);
    cmp_count++;
    if (rdv !== {24'h00_0000, exp})
    begin
      errors++;
      $display("unexpected at %0t: read %h, expected %h", $time, rdv, exp);
    end
  endtask : chk

  // Compare of the slave error answer.
  task automatic chk_err(input logic exp);
    cmp_count++;
    if (er !== exp)
    begin
      errors++;
      $display("unexpected at %0t: pslverr %b", $time, er);
    end
  endtask : chk_err

  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(exp);
  endtask : rd

  // Two keys back to back, then write go with permit kept on.
  task automatic unlock_go();
    bus(1'b1, `NVM_UNLOCK_IDX, 8'h55);
    bus(1'b1, `NVM_UNLOCK_IDX, 8'hAA);
    bus(1'b1, `NVM_CTRL_IDX, 8'h06);
  endtask : unlock_go

  task automatic pulse_soft();
    @(posedge clock);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
  endtask : pulse_soft

  // Fixed fields, refused starts and a broken key sequence.
  task automatic t_fields();
    rd(`NVM_CTRL_IDX, 8'h00);
    bus(1'b1, `NVM_CTRL_IDX, 8'hF4);
    rd(`NVM_CTRL_IDX, 8'h04);
    bus(1'b1, `NVM_UNLOCK_IDX, 8'h12);
    rd(`NVM_UNLOCK_IDX, 8'h00);
    bus(1'b1, `NVM_CTRL_IDX, 8'h00);
    bus(1'b1, `NVM_UNLOCK_IDX, 8'h55);
    bus(1'b1, `NVM_UNLOCK_IDX, 8'hAA);
    bus(1'b1, `NVM_CTRL_IDX, 8'h02);
    rd(`NVM_CTRL_IDX, 8'h00);
    bus(1'b1, `NVM_CTRL_IDX, 8'h04);
    bus(1'b1, `NVM_UNLOCK_IDX, 8'h55);
    rd(`NVM_CTRL_IDX, 8'h04);
    bus(1'b1, `NVM_UNLOCK_IDX, 8'hAA);
    bus(1'b1, `NVM_CTRL_IDX, 8'h06);
    rd(`NVM_CTRL_IDX, 8'h04);
    bus(1'b0, 10'h3FF, 8'h00);
    chk_err(1'b1);
  endtask : t_fields

  // Full write under protection, permit dropped mid-write, then a read back.
  task automatic t_write();
    int n;
    code_protect <= 1'b1;
    bus(1'b1, `NVM_DATA_IDX, 8'h3C);
    bus(1'b1, `NVM_ADDR_IDX, 8'h05);
    unlock_go();
    rd(`NVM_CTRL_IDX, 8'h06);
    bus(1'b1, `NVM_CTRL_IDX, 8'h00);
    rd(`NVM_CTRL_IDX, 8'h02);
    // A low clock enable freezes the write timer, so the write outlasts its nominal span.
    @(posedge clock);
    ce <= 1'b0;
    repeat (50) @(posedge clock);
    ce <= 1'b1;
    rd(`NVM_CTRL_IDX, 8'h02);
    n = 0;
    bus(1'b0, `NVM_CTRL_IDX, 8'h00);
    while (rdv[1] !== 1'b0 && n < 30)
    begin
      n++;
      bus(1'b0, `NVM_CTRL_IDX, 8'h00);
    end
    chk(8'h00);
    rd(`NVM_FLAG_IDX, 8'h05);
    bus(1'b1, `NVM_FLAG_IDX, 8'h01);
    rd(`NVM_FLAG_IDX, 8'h04);
    bus(1'b1, `NVM_DATA_IDX, 8'h00);
    bus(1'b1, `NVM_CTRL_IDX, 8'h01);
    rd(`NVM_CTRL_IDX, 8'h00);
    rd(`NVM_DATA_IDX, 8'h3C);
  endtask : t_write

  // Other resets keep data and address, and flag a write cut short.
  task automatic t_soft();
    bus(1'b1, `NVM_CTRL_IDX, 8'h04);
    pulse_soft();
    rd(`NVM_CTRL_IDX, 8'h00);
    rd(`NVM_DATA_IDX, 8'h3C);
    rd(`NVM_ADDR_IDX, 8'h05);
    bus(1'b1, `NVM_CTRL_IDX, 8'h04);
    unlock_go();
    pulse_soft();
    rd(`NVM_CTRL_IDX, 8'h08);
  endtask : t_soft

  task automatic results();
    $display("errors %0d, comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // Watchdog well beyond the few hundred clock cycles of the run.
  initial
  begin
    #400000;
    errors++;
    results();
  end

  // Main sequence: power-on reset for four cycles, then the scenarios.
  initial
  begin
    reset = 1'b1;
    soft_reset = 1'b0;
    ce = 1'b1;
    code_protect = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    t_fields();
    t_write();
    t_soft();
    results();
  end
endmodule : test_data_nvm_register_access

`default_nettype wire
